/* File: core/ddmr_mode_regs.sv */
// Behaviour
// - Decode first extended write on all strobes low, BA1 low, BA0 high.
// - First extended register fields: DLL, half drive, latency, termination, cal, DQS#.
// - DLL turns off in self refresh and back on at exit.
// - Decode second extended write on strobes low, BA1 high, BA0 low.
// - Second extended A7 raises self-refresh rate above 85C when supported.
// - Second extended A3 may control the duty cycle corrector.
// - Calibration field: 000 exit, 001 high, 010 low, 100 adjust, 111 default.
// - Drive high: DQ and DQS high, DQS# low; drive low inverts.
// - Apply adjust code to all drivers; listed codes step pull-up/pull-down.
// - Steps limited to sixteen; stepping past the limit does nothing.
// - Default drive valid only at full strength and without adjustment.
// - Decode base register write on strobes and BA0, BA1 low.
// - Decode third extended write with BA2 low, BA0 and BA1 high.
`include "ddmr_map.svh"

module ddmr_mode_regs #(
  parameter int unsigned STEPS = 16
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Command and address pins
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [2:0]        ba,
  input  wire ddmr_pkg::ddmr_mreg_t addr,
  input  wire logic              dq_bit,
  // Software register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Data pin drive during calibration
  output logic [15:0]            dq_out,
  output logic                   dq_oe,
  output logic [1:0]             dqs_out,
  output logic [1:0]             dqs_n_out,
  output logic                   dqs_oe,
  // Decoded settings
  output logic                   dll_enable,
  output logic                   half_strength,
  output logic [2:0]             additive_latency,
  output logic [1:0]             rtt_sel,
  output logic                   dqs_n_disable,
  output logic                   output_disable,
  output logic                   high_temp_sr,
  output logic                   dcc_enable,
  output logic                   default_drive,
  output ddmr_pkg::ddmr_step_t   pu_step,
  output ddmr_pkg::ddmr_step_t   pd_step
);
  import ddmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Map a calibration field to its mode; undefined codes exit
  function automatic ddmr_cal_e cal_decode(input logic [2:0] f);
    unique case (f)
      `DDMR_CAL_HI:  cal_decode = CAL_DRIVE_HI;
      `DDMR_CAL_LO:  cal_decode = CAL_DRIVE_LO;
      `DDMR_CAL_ADJ: cal_decode = CAL_ADJUST;
      `DDMR_CAL_DEF: cal_decode = CAL_DEFAULT;
      default:       cal_decode = CAL_EXIT;
    endcase
  endfunction

  // Adjust code {DT0..DT3} to {pd_dec, pd_inc, pu_dec, pu_inc}
  function automatic logic [3:0] adj_decode(input logic [3:0] c);
    unique case (c)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'hA: adj_decode = c;
      default: adj_decode = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release and state

  logic       rst_sync_n;
  ddmr_core_s st;
  ddmr_core_s next_st;

  ddmr_rst_sync u_rst (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  logic       cmd_set;
  logic       cmd_write;
  logic       cmd_sr_entry;
  logic       wr_mr;
  logic       wr_e1;
  logic       wr_e2;
  logic       wr_e3;
  logic [3:0] adj_act;
  logic       adj_done;
  logic       def_load;

  // Register-set needs CKE high now and one cycle back
  assign cmd_set      = !cs_n && !ras_n && !cas_n && !we_n && cke && st.cke_q;
  assign cmd_write    = !cs_n && ras_n && !cas_n && !we_n && cke;
  assign cmd_sr_entry = !cs_n && !ras_n && !cas_n && we_n && st.cke_q && !cke;
  assign wr_mr = cmd_set && ba[1:0] == `DDMR_BA_MR;
  assign wr_e1 = cmd_set && ba[1:0] == `DDMR_BA_EMR1;
  assign wr_e2 = cmd_set && ba[1:0] == `DDMR_BA_EMR2;
  // Only the third extended register checks BA2
  assign wr_e3 = cmd_set && ba[1:0] == `DDMR_BA_EMR3 && !ba[2];

  // Last bit time of a burst; a register-set in the same cycle aborts it
  assign adj_done = st.adj_busy && st.adj_cnt == `DDMR_ADJ_LAST && !cmd_set;
  // Code arrives first bit time first, so DT0 ends at the top
  assign adj_act  = adj_done ? adj_decode({st.adj_bits[2:0], dq_bit})
                             : 4'h0;
  // Only the default code reloads; exit and the rest keep the steps
  assign def_load = wr_e1 &&
                    addr[`DDMR_E1_CAL_LSB +: 3] == `DDMR_CAL_DEF;

  ////////////////////////////////////////////////////////////////////////
  // Driver strength steps, shared by every DQ driver

  ddmr_step_cnt #(.STEPS(STEPS)) u_pu (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .load     (def_load),
    .load_val (`DDMR_STEP_DEF),
    .inc      (adj_act[0]),
    .dec      (adj_act[1]),
    .step     (pu_step)
  );

  ddmr_step_cnt #(.STEPS(STEPS)) u_pd (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .load     (def_load),
    .load_val (`DDMR_STEP_DEF),
    .inc      (adj_act[2]),
    .dec      (adj_act[3]),
    .step     (pd_step)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st       = st;
    next_st.cke_q = cke;
    next_st.rdata = 32'h0000_0000;
    // Register writes from the command bus
    if (wr_mr) begin
      next_st.mr = addr;
    end
    if (wr_e1) begin
      next_st.emr1     = addr;
      next_st.cal_mode = cal_decode(addr[`DDMR_E1_CAL_LSB +: 3]);
      next_st.adj_busy = 1'b0;
    end
    if (wr_e2) begin
      next_st.emr2 = addr;
    end
    if (wr_e3) begin
      next_st.emr3 = addr;
    end
    // Default load clears any earlier adjustment
    if (def_load) begin
      next_st.def_set  = 1'b1;
      next_st.adjusted = 1'b0;
    end
    // Adjust burst capture after a write in adjust mode
    if (cmd_set) begin
      next_st.adj_busy = 1'b0;
    end else if (st.adj_busy) begin
      next_st.adj_bits = {st.adj_bits[2:0], dq_bit};
      next_st.adj_cnt  = st.adj_cnt + 2'h1;
      if (st.adj_cnt == `DDMR_ADJ_LAST) begin
        next_st.adj_busy = 1'b0;
      end
    end else if (cmd_write && st.cal_mode == CAL_ADJUST) begin
      next_st.adj_busy = 1'b1;
      next_st.adj_cnt  = 2'h0;
    end
    if (adj_done) begin
      next_st.adjusted = 1'b1;
    end
    // Self refresh tracking
    if (cmd_sr_entry) begin
      next_st.self_ref = 1'b1;
    end else if (st.self_ref && cke) begin
      next_st.self_ref = 1'b0;
    end
    // Software port
    if (reg_wr && reg_addr == `DDMR_OFF_CTRL) begin
      next_st.ctrl = reg_wdata[1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `DDMR_OFF_CTRL: next_st.rdata = {30'h0, st.ctrl};
        `DDMR_OFF_MR:   next_st.rdata = {19'h0, st.mr};
        `DDMR_OFF_EMR1: next_st.rdata = {19'h0, st.emr1};
        `DDMR_OFF_EMR2: next_st.rdata = {19'h0, st.emr2};
        `DDMR_OFF_EMR3: next_st.rdata = {19'h0, st.emr3};
        `DDMR_OFF_CAL:  next_st.rdata = {20'h0, default_drive,
                                         st.cal_mode, pd_step, pu_step};
        `DDMR_OFF_STAT: next_st.rdata = {30'h0, st.self_ref, dll_enable};
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st          <= '0;
      st.mr       <= `DDMR_MREG_RST;
      st.emr1     <= `DDMR_MREG_RST;
      st.emr2     <= `DDMR_MREG_RST;
      st.emr3     <= `DDMR_MREG_RST;
      st.cal_mode <= CAL_EXIT;
      st.ctrl     <= `DDMR_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // DLL follows the register unless self refresh holds it off
  assign dll_enable       = !st.emr1[`DDMR_E1_DLL] && !st.self_ref;
  assign half_strength    = st.emr1[`DDMR_E1_HALF];
  assign additive_latency = st.emr1[`DDMR_E1_AL_LSB +: 3];
  assign rtt_sel          = {st.emr1[`DDMR_E1_RTT_HI], st.emr1[`DDMR_E1_RTT_LO]};
  assign dqs_n_disable    = st.emr1[`DDMR_E1_DQSN];
  assign output_disable   = st.emr1[`DDMR_E1_QOFF];
  // Gated by software straps since not every part has these features
  assign high_temp_sr     = st.emr2[`DDMR_E2_SRT] && st.ctrl[0];
  assign dcc_enable       = st.emr2[`DDMR_E2_DCC] && st.ctrl[1];
  assign default_drive    = st.def_set && !st.adjusted && !half_strength;
  assign reg_rdata        = st.rdata;

  // Calibration drive levels
  assign dq_oe     = st.cal_mode == CAL_DRIVE_HI || st.cal_mode == CAL_DRIVE_LO;
  assign dqs_oe    = dq_oe;
  assign dq_out    = (st.cal_mode == CAL_DRIVE_HI) ? 16'hFFFF : 16'h0000;
  assign dqs_out   = (st.cal_mode == CAL_DRIVE_HI) ? 2'h3 : 2'h0;
  assign dqs_n_out = (st.cal_mode == CAL_DRIVE_LO) ? 2'h3 : 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_mr_wr;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_mr |=> st.mr == $past(addr);
  endproperty
  a_mr_wr: assert property (p_mr_wr) else $error("base write lost");

  property p_e1_wr;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 |=> additive_latency == $past(addr[5:3])
              && rtt_sel == {$past(addr[6]), $past(addr[2])};
  endproperty
  a_e1_wr: assert property (p_e1_wr) else $error("ext one fields wrong");

  property p_e2_wr;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e2 |=> high_temp_sr == ($past(addr[7]) && st.ctrl[0]);
  endproperty
  a_e2_wr: assert property (p_e2_wr) else $error("ext two rate wrong");

  property p_e3_wr;
    @(posedge core_clk) disable iff (!rst_sync_n)
    cmd_set && ba == 3'h7 |=> $stable(st.emr3);
  endproperty
  a_e3_wr: assert property (p_e3_wr) else $error("ext three took BA2 high");

  property p_dll_sr;
    @(posedge core_clk) disable iff (!rst_sync_n)
    cmd_sr_entry |=> st.self_ref && !dll_enable;
  endproperty
  a_dll_sr: assert property (p_dll_sr) else $error("dll on in self refresh");

  property p_drive;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 && addr[9:7] == 3'h1 |=> dq_oe && dq_out == 16'hFFFF && dqs_n_out == 2'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("drive high wrong");

  property p_cal_lo;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 && addr[9:7] == 3'h2 |=> st.cal_mode == CAL_DRIVE_LO && dqs_n_out == 2'h3;
  endproperty
  a_cal_lo: assert property (p_cal_lo) else $error("drive low decode wrong");

  property p_exit_hold;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 && addr[9:7] == 3'h0 |=> $stable(pu_step) && $stable(pd_step);
  endproperty
  a_exit_hold: assert property (p_exit_hold) else $error("exit moved steps");

  property p_adj_up;
    @(posedge core_clk) disable iff (!rst_sync_n)
    adj_act[0] && !adj_act[1] && pu_step != 4'hF |=> pu_step == $past(pu_step) + 4'h1;
  endproperty
  a_adj_up: assert property (p_adj_up) else $error("pull-up step missed");

  property p_half;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 && addr[1] |=> !default_drive;
  endproperty
  a_half: assert property (p_half) else $error("default at half drive");

  c_adjust: cover property (@(posedge core_clk) disable iff (!rst_sync_n) adj_done);
  c_sr_exit: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    $fell(st.self_ref));
  c_default: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    default_drive);

  // Exit must release the pins, or the bus fights the controller
  property p_oe_exit;
    @(posedge core_clk) disable iff (!rst_sync_n)
    wr_e1 && addr[9:7] == 3'h0 |=> !dq_oe && !dqs_oe;
  endproperty
  a_oe_exit: assert property (p_oe_exit) else $error("exit left drivers on");

  property p_pd_floor;
    @(posedge core_clk) disable iff (!rst_sync_n)
    adj_act[3] && pd_step == 4'h0 |=> pd_step == 4'h0;
  endproperty
  a_pd_floor: assert property (p_pd_floor) else $error("pull-down below floor");

  c_drive_lo: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
    st.cal_mode == CAL_DRIVE_LO);
endmodule // ddmr_mode_regs

/* File: core/ddmr_rst_sync.sv */
module ddmr_rst_sync (
  // Clock and raw reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Released reset
  output logic      rst_sync_n
);
  import ddmr_pkg::*;
  ddmr_rst_s st;
  ddmr_rst_s next_st;

  // Shift ones in after release; assert at once
  always_comb begin
    next_st.sync = {st.sync[0], 1'b1};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rst_sync_n = st.sync[1];
endmodule // ddmr_rst_sync

/* File: core/ddmr_step_cnt.sv */
`include "ddmr_map.svh"

module ddmr_step_cnt #(
  parameter int unsigned STEPS = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        load,
  input  wire ddmr_pkg::ddmr_step_t load_val,
  input  wire logic        inc,
  input  wire logic        dec,
  // Current step
  output ddmr_pkg::ddmr_step_t step
);
  import ddmr_pkg::*;
  localparam ddmr_step_t MAX = ddmr_step_t'(STEPS - 1);
  ddmr_step_s st;
  ddmr_step_s next_st;

  // Saturate at both ends so a code past the limit does nothing
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.step = load_val;
    end else if (inc && !dec && st.step != MAX) begin
      next_st.step = st.step + 4'h1;
    end else if (dec && !inc && st.step != 4'h0) begin
      next_st.step = st.step - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.step <= `DDMR_STEP_DEF;
    end else begin
      st <= next_st;
    end
  end

  assign step = st.step;

  // Increment at the top must not wrap to zero
  property p_sat_top;
    @(posedge core_clk) disable iff (!rst_n)
    st.step == MAX && inc && !dec && !load |=> st.step == MAX;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("step wrapped at top");
endmodule // ddmr_step_cnt

/* File: inc/ddmr_map.svh */
`ifndef DDMR_MAP_SVH
`define DDMR_MAP_SVH
// Bank select codes of a register-set command
`define DDMR_BA_MR      2'h0
`define DDMR_BA_EMR1    2'h1
`define DDMR_BA_EMR2    2'h2
`define DDMR_BA_EMR3    2'h3
// Field positions of the first extended register
`define DDMR_E1_DLL     0
`define DDMR_E1_HALF    1
`define DDMR_E1_RTT_LO  2
`define DDMR_E1_AL_LSB  3
`define DDMR_E1_RTT_HI  6
`define DDMR_E1_CAL_LSB 7
`define DDMR_E1_DQSN    10
`define DDMR_E1_QOFF    12
// Field positions of the second extended register
`define DDMR_E2_DCC     3
`define DDMR_E2_SRT     7
// Calibration field codes
`define DDMR_CAL_EXIT   3'h0
`define DDMR_CAL_HI     3'h1
`define DDMR_CAL_LO     3'h2
`define DDMR_CAL_ADJ    3'h4
`define DDMR_CAL_DEF    3'h7
// Reset values
`define DDMR_MREG_RST   13'h0000
`define DDMR_CTRL_RST   2'h0
`define DDMR_STEP_DEF   4'h8
// Software register offsets
`define DDMR_OFF_CTRL   8'h00
`define DDMR_OFF_MR     8'h04
`define DDMR_OFF_EMR1   8'h08
`define DDMR_OFF_EMR2   8'h0C
`define DDMR_OFF_EMR3   8'h10
`define DDMR_OFF_CAL    8'h14
`define DDMR_OFF_STAT   8'h18
// Index of the last bit time in an adjust burst, counted from zero
`define DDMR_ADJ_LAST   2'h3
`endif

/* File: inc/ddmr_pkg.sv */
package ddmr_pkg;
  typedef logic [12:0] ddmr_mreg_t;
  typedef logic [3:0]  ddmr_step_t;
  typedef enum logic [2:0] {
    CAL_EXIT, CAL_DRIVE_HI, CAL_DRIVE_LO, CAL_ADJUST, CAL_DEFAULT
  } ddmr_cal_e;
  typedef struct packed {
    logic [1:0] sync;
  } ddmr_rst_s;
  typedef struct packed {
    ddmr_step_t step;
  } ddmr_step_s;
  typedef struct packed {
    ddmr_mreg_t mr;
    ddmr_mreg_t emr1;
    ddmr_mreg_t emr2;
    ddmr_mreg_t emr3;
    ddmr_cal_e  cal_mode;
    logic       adj_busy;
    logic [1:0] adj_cnt;
    logic [3:0] adj_bits;
    logic       self_ref;
    logic       cke_q;
    logic       def_set;
    logic       adjusted;
    logic [1:0] ctrl;
    logic [31:0] rdata;
  } ddmr_core_s;
endpackage : ddmr_pkg

/* File: tb/ddmr_ctrl_model.sv */
module ddmr_ctrl_model #(
  parameter int REGISTER_SET_CYCLE_TIME     = 2,
  parameter int DLL_LOCK = 200,
  parameter int T_WR_PS  = 15000,
  parameter int T_CK_PS  = 2500,
  parameter int WR_LSB   = 9
) (
  // Clock
  input  wire logic   core_clk,
  // Command pins
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [12:0] addr,
  // Adjust burst bit
  output logic        dq_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rounded-up recovery count
  localparam int WR_CYC = (T_WR_PS + T_CK_PS - 1) / T_CK_PS;
  localparam logic [12:0] BASE_BL4 = 13'((WR_CYC - 1) << WR_LSB) | 13'h0002;
  ////////////////////////////////////////
  // Idle pins before the first command
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 13'h0000;
    dq_bit = 1'b0;
  end
  // Deselected cycles; free lines flip so stale values never pass
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      ba <= ~ba;
      addr <= ~addr;
      dq_bit <= ~dq_bit;
    end
  endtask
  // One command, held through the edge that takes it
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    idle(1);
  endtask
  // Register set with reserved bits cleared
  task automatic reg_set(input logic [1:0] b, input logic [12:0] a);
    logic [12:0] v;
    v = a;
    if (b == 2'h1) v[11] = 1'b0;
    if (b == 2'h2) v = v & 13'h0087;
    if (b == 2'h3) v = 13'h0000;
    cmd(4'h0, {1'b0, b}, v);
    idle(REGISTER_SET_CYCLE_TIME - 1);
  endtask
  // Burst four, then lock time before any calibration
  task automatic setup();
    reg_set(2'h0, BASE_BL4);
    idle(DLL_LOCK);
  endtask
  // Adjust entry, write with a 4-bit burst, then exit
  task automatic adjust(input logic [12:0] e1, input logic [3:0] code);
    int i;
    reg_set(2'h1, (e1 & ~13'h0380) | 13'h0200);
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h4;
    ba <= 3'h0;
    addr <= 13'h0000;
    for (i = 3; i >= 0; i--) begin
      @(posedge core_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      dq_bit <= code[i];
    end
    idle(2);
    reg_set(2'h1, e1 & ~13'h0380);
  endtask
  // Self refresh entry drops clock enable; exit raises it
  task automatic self_ref(input logic enter);
    @(posedge core_clk);
    cke <= ~enter;
    {cs_n, ras_n, cas_n, we_n} <= enter ? 4'h1 : 4'hF;
    idle(2);
  endtask
endmodule // ddmr_ctrl_model

/* File: tb/tb_top.sv */
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddmr_pkg::*;
  localparam int SMAX = 15;
  // Clock, reset and register port
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  // Command pins
  logic        cke, cs_n, ras_n, cas_n, we_n, dq_bit;
  logic [2:0]  ba;
  logic [12:0] addr;
  // Device outputs
  logic [15:0] dq_out;
  logic [1:0]  dqs_out, dqs_n_out, rtt_sel;
  logic [2:0]  additive_latency;
  logic        dq_oe, dqs_oe, dll_enable, half_strength, dqs_n_disable;
  logic        output_disable, high_temp_sr, dcc_enable, default_drive;
  ddmr_step_t  pu_step, pd_step;
  // Bench state
  int          mismatches, comparisons, cycles, pu_e, pd_e, n;
  logic [31:0] rd;
  logic [12:0] v;
  logic [3:0]  c;

  ddmr_mode_regs #(.STEPS(16)) i_ddmr_mode_regs (
    .core_clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_bit,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dq_out, .dq_oe, .dqs_out,
    .dqs_n_out, .dqs_oe, .dll_enable, .half_strength, .additive_latency, .rtt_sel,
    .dqs_n_disable, .output_disable, .high_temp_sr, .dcc_enable, .default_drive,
    .pu_step, .pd_step
  );
  ddmr_ctrl_model ctl (
    .core_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_bit
  );
  ////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////
  // Register port cycles
  task automatic rwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rd = reg_rdata;
    `CHK(rd, e)
  endtask
  // Expected step after one adjust half-code, clamped to the range
  function automatic int nudge(input int s, input logic [1:0] h);
    int t;
    t = (h == 2'b01) ? s + 1 : (h == 2'b10) ? s - 1 : s;
    return (t > SMAX) ? SMAX : (t < 0) ? 0 : t;
  endfunction
  function automatic logic [31:0] calw(input logic d, input logic [2:0] m);
    return {20'h0, d, m, 4'(pd_e), 4'(pu_e)};
  endfunction
  task automatic close_out();
    $display("Counts: mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    n = $urandom(32'h02B2);
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pu_e = 8;
    pd_e = 8;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    ctl.idle(4);
    @(negedge core_clk);
    `CHK({dll_enable, pu_step, pd_step, dq_oe}, {1'b1, 8'h88, 1'b0})
    rchk(8'h14, 32'h88);
    rchk(8'h1C, 32'h0);
    rwr(8'h18, 32'h3);
    rchk(8'h18, 32'h1);
    // Random field decode of the base, first and second extended registers and straps
    for (n = 0; n < 16; n++) begin
      v = 13'($urandom());
      v[9:7] = 3'h0;
      c = 4'($urandom());
      ctl.reg_set(2'h1, v);
      ctl.reg_set(2'h0, ~v);
      rwr(8'h00, {30'h0, c[1:0]});
      ctl.reg_set(2'h2, v);
      @(negedge core_clk);
      `CHK({dll_enable, half_strength, additive_latency}, {~v[0], v[1], v[5:3]})
      `CHK({rtt_sel, dqs_n_disable, output_disable}, {v[6], v[2], v[10], v[12]})
      `CHK({high_temp_sr, dcc_enable}, {c[0] & v[7], 1'b0})
      rchk(8'h08, {19'h0, v[12], 1'b0, v[10:0]});
      rchk(8'h04, {19'h0, ~v});
      rchk(8'h0C, {19'h0, v & 13'h0087});
      rchk(8'h00, {30'h0, c[1:0]});
    end
    // Later rewrite with the corrector bit set, straps on then off
    rwr(8'h00, 32'h3);
    ctl.cmd(4'h0, 3'h2, 13'h0088);
    @(negedge core_clk);
    `CHK({high_temp_sr, dcc_enable}, 2'b11)
    rwr(8'h00, 32'h0);
    @(negedge core_clk);
    `CHK({high_temp_sr, dcc_enable}, 2'b00)
    // Third register decode and refusal
    ctl.cmd(4'h0, 3'h7, 13'h0155);
    rchk(8'h10, 32'h0);
    ctl.cmd(4'h0, 3'h3, 13'h0155);
    rchk(8'h10, 32'h155);
    ctl.reg_set(2'h3, 13'h0000);
    rchk(8'h10, 32'h0);
    // Drive-high and drive-low, each left by exit
    ctl.setup();
    for (n = 1; n < 3; n++) begin
      ctl.reg_set(2'h1, 13'(n << 7) | 13'h0018);
      @(negedge core_clk);
      `CHK({dq_oe, dqs_oe, dq_out}, {2'b11, {16{n == 1}}})
      `CHK({dqs_out, dqs_n_out}, {{2{n == 1}}, {2{n != 1}}})
      rchk(8'h14, calw(1'b0, 3'(n)));
      ctl.reg_set(2'h1, 13'h0018);
      @(negedge core_clk);
      `CHK({dq_oe, dqs_oe}, 2'b00)
    end
    // Adjust: saturate both ends, then random codes
    for (n = 0; n < 60; n++) begin
      c = (n < 8) ? 4'h5 : (n == 8) ? 4'h1 : (n < 26) ? 4'hA : 4'h8;
      if (n > 26) c = 4'($urandom());
      ctl.adjust(13'h0018, c);
      if (c[1:0] != 2'b11 && c[3:2] != 2'b11) begin
        pu_e = nudge(pu_e, c[1:0]);
        pd_e = nudge(pd_e, c[3:2]);
      end
      @(negedge core_clk);
      `CHK({pu_step, pd_step}, {4'(pu_e), 4'(pd_e)})
    end
    `CHK({default_drive, additive_latency}, 4'h3)
    // Default reloads the steps; half strength voids it
    ctl.reg_set(2'h1, 13'h0398);
    ctl.reg_set(2'h1, 13'h0018);
    pu_e = 8;
    pd_e = 8;
    rchk(8'h14, calw(1'b1, 3'h0));
    ctl.reg_set(2'h1, 13'h001A);
    @(negedge core_clk);
    `CHK(default_drive, 1'b0)
    // Full strength again restores it; any adjust burst voids it
    ctl.reg_set(2'h1, 13'h0018);
    @(negedge core_clk);
    `CHK(default_drive, 1'b1)
    ctl.adjust(13'h0018, 4'h0);
    @(negedge core_clk);
    `CHK({default_drive, pu_step, pd_step}, 9'h088)
    // Self refresh; a write with clock enable low is ignored
    ctl.reg_set(2'h1, 13'h0018);
    ctl.self_ref(1'b1);
    @(negedge core_clk);
    `CHK(dll_enable, 1'b0)
    rchk(8'h18, 32'h2);
    ctl.reg_set(2'h1, 13'h0001);
    ctl.self_ref(1'b0);
    @(negedge core_clk);
    `CHK(dll_enable, 1'b1)
    rchk(8'h18, 32'h1);
    close_out();
  end
endmodule // tb_top
